// >>> src/hpl_byte_buf.sv
// Two-entry byte buffer between the packet builder and the serialiser.
// Assumes both sides share core_clk_in; a stalled drain holds the filler.
`timescale 1ns/100ps
module hpl_byte_buf (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [7:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [7:0] out_data_out,
  input wire logic out_ready_in
);
  import hpl_pkg::*;

  logic [7:0] mem [2];
  logic [7:0] next_mem [2];
  logic wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [1:0] count, next_count;
  logic push, pop;

  assign in_ready_out = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) next_rd_ptr = ~rd_ptr;
    if (push && !pop) next_count = count + 2'h1;
    else if (pop && !push) next_count = count - 2'h1;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_buf_full_stall: assert property ((count == 2'h2 && !pop) |=>
    (count == 2'h2 && out_data_out == $past(out_data_out)))
    else $error("full buffer lost or overwrote its head byte");
  a_buf_word_kept: assert property (
    (push && count == 2'h0) |=> (out_valid_out && out_data_out ==
                                 $past(in_data_in)))
    else $error("buffered byte lost or altered");
  c_buf_fills: cover property (count == 2'h2 && in_valid_in);

endmodule : hpl_byte_buf

// >>> src/hpl_link.sv
// Packet framer for the host serial link: UART, receive parser, command
// answers, key and temperature reports, transmit builder and serialiser.
// Assumes synchronous pins, event pulses on the key inputs and a sensor
// value that follows temp_idx_out one cycle later.
// Function
// - Link starts at 19200 8N1; a command can switch it to 115200.
// - Packets go as type, length, payload, then check value.
// - Type top two bits give class; low six bits give the code.
// - Well formed but unacceptable packets get an error class reply unless an answer is still pending.
// - Length runs from zero to 18 and matches the payload count.
// - 16-bit CRC over type, length, payload; low byte sent first.
// - CRC follows the last used payload byte with no padding.
// - A received packet with a good CRC is answered within 250 ms unless an answer is still pending; a corrupt one is dropped.
// - Reports go out when ready, interleaved with answers.
// - Enabled key events send type 0x80 with one byte; 0x81 unused.
// - Key payload: presses 1 to 6, releases 7 to 12.
// - Each selected sensor of 32 sends a 0x82 report every second.
// - Each command taken while no answer is pending gets exactly one answer, response or error.
// - Answer type low six bits copy the command code.
// - A response type is the command code with bit 6 set.
`timescale 1ns/100ps
module hpl_link #(
  parameter int ANSWER_LIMIT = hpl_pkg::ANSWER_CYC,
  parameter int REPORT_PERIOD = hpl_pkg::REPORT_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Serial link
  input wire logic uart_rxd_in,
  output logic uart_txd_out,
  output logic baud_fast_out,
  // Keypad events and report enables
  input wire logic [hpl_pkg::NUM_KEYS-1:0] key_press_in,
  input wire logic [hpl_pkg::NUM_KEYS-1:0] key_release_in,
  input wire logic [hpl_pkg::NUM_KEYS-1:0] key_press_mask_in,
  input wire logic [hpl_pkg::NUM_KEYS-1:0] key_release_mask_in,
  // Temperature sensors
  input wire logic [hpl_pkg::NUM_SENSORS-1:0] temp_select_in,
  output logic [4:0] temp_idx_out,
  input wire logic [15:0] temp_data_in
);
  import hpl_pkg::*;

  typedef enum logic [3:0] {R_IDLE = 4'b0001, R_START = 4'b0010,
    R_DATA = 4'b0100, R_STOP = 4'b1000} hpl_uart_t;
  typedef enum logic [4:0] {P_TYPE = 5'b00001, P_LEN = 5'b00010,
    P_DATA = 5'b00100, P_CRCL = 5'b01000, P_CRCH = 5'b10000} hpl_parse_t;
  typedef enum logic [5:0] {B_IDLE = 6'b000001, B_TYPE = 6'b000010,
    B_LEN = 6'b000100, B_DATA = 6'b001000, B_CRCL = 6'b010000,
    B_CRCH = 6'b100000} hpl_build_t;

  // Shared wires between groups
  logic [DIV_W-1:0] div;
  logic rx_byte_vld, ans_done, push, push_ok, buf_rdy;
  logic buf_vld, buf_pop, line_idle;
  logic [7:0] buf_data, cur_byte;
  logic [11:0] key_clr;
  logic [31:0] temp_clr;

  assign div = baud_fast_out ? DIV_FAST : DIV_SLOW;

  ////////////////////////////////////////////////////////////////////////
  // Receive: UART, parser, answer bookkeeping and rate change
  hpl_uart_t rx_st, next_rx_st;
  logic [DIV_W-1:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  hpl_parse_t p_st, next_p_st;
  logic [7:0] p_type, next_p_type, p_len, next_p_len;
  logic [7:0] p_crcl, next_p_crcl;
  logic [4:0] p_cnt, next_p_cnt;
  logic [15:0] p_crc, next_p_crc;
  logic [7:0] pay [MAX_PAY];
  logic [7:0] next_pay [MAX_PAY];
  logic ans_pend, next_ans_pend, ans_err, next_ans_err;
  logic [5:0] ans_code, next_ans_code;
  logic [7:0] ans_len, next_ans_len;
  logic [AGE_W-1:0] ans_age, next_ans_age;
  logic baud_req, next_baud_req, baud_val, next_baud_val, next_baud_fast;
  logic crc_ok, acc_ok;

  assign crc_ok = ({rx_sh, p_crcl} == ~p_crc);
  assign acc_ok = (p_type[7:6] == CLS_CMD) &&
    ((p_type[5:0] == CODE_PING && p_len <= PING_MAX_LEN) ||
     (p_type[5:0] == CODE_BAUD && p_len == BAUD_LEN &&
      pay[0] <= BAUD_SEL_FAST));

  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    rx_byte_vld = 1'b0;
    case (rx_st)
      R_IDLE: if (!uart_rxd_in) begin
        next_rx_st = R_START;
        next_rx_cnt = div >> 1;
      end
      R_START: if (rx_cnt != '0) next_rx_cnt = rx_cnt - 1'b1;
      else if (uart_rxd_in) next_rx_st = R_IDLE;
      else begin
        next_rx_st = R_DATA;
        next_rx_cnt = div - 1'b1;
        next_rx_bit = 3'h0;
      end
      R_DATA: if (rx_cnt != '0) next_rx_cnt = rx_cnt - 1'b1;
      else begin
        next_rx_sh = {uart_rxd_in, rx_sh[7:1]};
        next_rx_cnt = div - 1'b1;
        next_rx_bit = rx_bit + 3'h1;
        if (rx_bit == 3'h7) next_rx_st = R_STOP;
      end
      default: if (rx_cnt != '0) next_rx_cnt = rx_cnt - 1'b1;
      else begin
        // A missing stop bit drops the byte; the parser then resyncs
        next_rx_st = R_IDLE;
        rx_byte_vld = uart_rxd_in;
      end
    endcase
  end

  always_comb begin
    next_p_st = p_st;
    next_p_type = p_type;
    next_p_len = p_len;
    next_p_crcl = p_crcl;
    next_p_cnt = p_cnt;
    next_p_crc = p_crc;
    next_pay = pay;
    next_ans_pend = ans_pend && !ans_done;
    next_ans_err = ans_err;
    next_ans_code = ans_code;
    next_ans_len = ans_len;
    next_ans_age = ans_pend ? ans_age + 1'b1 : '0;
    next_baud_req = baud_req;
    next_baud_val = baud_val;
    next_baud_fast = baud_fast_out;
    if (baud_req && !ans_pend && line_idle) begin
      next_baud_fast = baud_val;
      next_baud_req = 1'b0;
    end
    if (rx_byte_vld) begin
      case (p_st)
        P_TYPE: begin
          next_p_type = rx_sh;
          next_p_crc = crc_step(CRC_INIT, rx_sh);
          next_p_st = P_LEN;
        end
        P_LEN: if (rx_sh > MAX_LEN) next_p_st = P_TYPE;
        else begin
          next_p_len = rx_sh;
          next_p_cnt = 5'h00;
          next_p_crc = crc_step(p_crc, rx_sh);
          next_p_st = (rx_sh == 8'h00) ? P_CRCL : P_DATA;
        end
        P_DATA: begin
          // Held payload belongs to the pending answer until it is sent
          if (!ans_pend) next_pay[p_cnt] = rx_sh;
          next_p_crc = crc_step(p_crc, rx_sh);
          next_p_cnt = p_cnt + 5'h01;
          if ({3'h0, p_cnt} == p_len - 8'h01) next_p_st = P_CRCL;
        end
        P_CRCL: begin
          next_p_crcl = rx_sh;
          next_p_st = P_CRCH;
        end
        default: begin
          next_p_st = P_TYPE;
          if (crc_ok && !ans_pend) begin
            next_ans_pend = 1'b1;
            next_ans_err = !acc_ok;
            next_ans_code = p_type[5:0];
            next_ans_len = (acc_ok && p_type[5:0] == CODE_PING) ?
                           p_len : 8'h00;
            if (acc_ok && p_type[5:0] == CODE_BAUD) begin
              next_baud_req = 1'b1;
              next_baud_val = (pay[0] == BAUD_SEL_FAST);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_st <= R_IDLE;
      rx_cnt <= '0;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      p_st <= P_TYPE;
      p_type <= 8'h00;
      p_len <= 8'h00;
      p_crcl <= 8'h00;
      p_cnt <= 5'h00;
      p_crc <= CRC_INIT;
      for (int i = 0; i < MAX_PAY; i++) pay[i] <= 8'h00;
      ans_pend <= 1'b0;
      ans_err <= 1'b0;
      ans_code <= 6'h00;
      ans_len <= 8'h00;
      ans_age <= '0;
      baud_req <= 1'b0;
      baud_val <= 1'b0;
      baud_fast_out <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      p_st <= next_p_st;
      p_type <= next_p_type;
      p_len <= next_p_len;
      p_crcl <= next_p_crcl;
      p_cnt <= next_p_cnt;
      p_crc <= next_p_crc;
      pay <= next_pay;
      ans_pend <= next_ans_pend;
      ans_err <= next_ans_err;
      ans_code <= next_ans_code;
      ans_len <= next_ans_len;
      ans_age <= next_ans_age;
      baud_req <= next_baud_req;
      baud_val <= next_baud_val;
      baud_fast_out <= next_baud_fast;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Report sources; a new event wins over the clear of the same bit
  logic [11:0] key_pend, next_key_pend;
  logic [31:0] temp_pend, next_temp_pend;
  logic [SEC_W-1:0] sec_cnt, next_sec_cnt;
  logic tick;

  assign tick = (sec_cnt == SEC_W'(REPORT_PERIOD - 1));

  always_comb begin
    next_sec_cnt = tick ? '0 : sec_cnt + 1'b1;
    next_key_pend = (key_pend & ~key_clr) |
      {key_release_in & key_release_mask_in,
       key_press_in & key_press_mask_in};
    next_temp_pend = (temp_pend & ~temp_clr) |
      (tick ? temp_select_in : 32'h0000_0000);
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sec_cnt <= '0;
      key_pend <= 12'h000;
      temp_pend <= 32'h0000_0000;
    end else begin
      sec_cnt <= next_sec_cnt;
      key_pend <= next_key_pend;
      temp_pend <= next_temp_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit packet builder
  hpl_build_t b_st, next_b_st;
  logic [1:0] b_src, next_b_src;
  logic [7:0] b_type, next_b_type, b_len, next_b_len;
  logic [7:0] key_code, next_key_code;
  logic [4:0] b_cnt, next_b_cnt, next_temp_idx, key_j, temp_j;
  logic [15:0] b_crc, next_b_crc;

  assign key_j = first_set({20'h00000, key_pend});
  assign temp_j = first_set(temp_pend);
  assign push = (b_st != B_IDLE);
  assign push_ok = push && buf_rdy;

  always_comb begin
    case (b_st)
      B_TYPE: cur_byte = b_type;
      B_LEN: cur_byte = b_len;
      B_DATA: if (b_src == SRC_ANS) cur_byte = pay[b_cnt];
      else if (b_src == SRC_KEY) cur_byte = key_code;
      else if (b_cnt == 5'h00) cur_byte = {3'h0, temp_idx_out};
      else if (b_cnt == 5'h01) cur_byte = temp_data_in[7:0];
      else cur_byte = temp_data_in[15:8];
      B_CRCL: cur_byte = ~b_crc[7:0];
      B_CRCH: cur_byte = ~b_crc[15:8];
      default: cur_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_b_st = b_st;
    next_b_src = b_src;
    next_b_type = b_type;
    next_b_len = b_len;
    next_b_cnt = b_cnt;
    next_b_crc = b_crc;
    next_key_code = key_code;
    next_temp_idx = temp_idx_out;
    key_clr = 12'h000;
    temp_clr = 32'h0000_0000;
    ans_done = 1'b0;
    if (b_st == B_IDLE) begin
      next_b_crc = CRC_INIT;
      next_b_cnt = 5'h00;
      // Answers first keep the deadline; reports fill every other gap
      if (ans_pend) begin
        next_b_st = B_TYPE;
        next_b_src = SRC_ANS;
        next_b_type = {ans_err ? CLS_ERR : CLS_RSP, ans_code};
        next_b_len = ans_len;
      end else if (key_pend != 12'h000) begin
        next_b_st = B_TYPE;
        next_b_src = SRC_KEY;
        next_b_type = TYPE_KEY;
        next_b_len = KEY_LEN;
        next_key_code = KEY_CODE_BASE + {3'h0, key_j};
        key_clr = 12'(32'h0000_0001 << key_j);
      end else if (temp_pend != 32'h0000_0000) begin
        next_b_st = B_TYPE;
        next_b_src = SRC_TEMP;
        next_b_type = TYPE_TEMP;
        next_b_len = TEMP_LEN;
        next_temp_idx = temp_j;
        temp_clr = 32'h0000_0001 << temp_j;
      end
    end else if (push_ok) begin
      // The check bytes themselves must stay out of the running CRC
      if (b_st != B_CRCL && b_st != B_CRCH)
        next_b_crc = crc_step(b_crc, cur_byte);
      case (b_st)
        B_TYPE: next_b_st = B_LEN;
        B_LEN: next_b_st = (b_len == 8'h00) ? B_CRCL : B_DATA;
        B_DATA: begin
          next_b_cnt = b_cnt + 5'h01;
          if ({3'h0, b_cnt} == b_len - 8'h01) next_b_st = B_CRCL;
        end
        B_CRCL: next_b_st = B_CRCH;
        default: begin
          next_b_st = B_IDLE;
          ans_done = (b_src == SRC_ANS);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      b_st <= B_IDLE;
      b_src <= SRC_ANS;
      b_type <= 8'h00;
      b_len <= 8'h00;
      b_cnt <= 5'h00;
      b_crc <= CRC_INIT;
      key_code <= 8'h00;
      temp_idx_out <= 5'h00;
    end else begin
      b_st <= next_b_st;
      b_src <= next_b_src;
      b_type <= next_b_type;
      b_len <= next_b_len;
      b_cnt <= next_b_cnt;
      b_crc <= next_b_crc;
      key_code <= next_key_code;
      temp_idx_out <= next_temp_idx;
    end
  end

  hpl_byte_buf u_buf (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(push),
    .in_data_in(cur_byte),
    .in_ready_out(buf_rdy),
    .out_valid_out(buf_vld),
    .out_data_out(buf_data),
    .out_ready_in(buf_pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Transmit serialiser
  hpl_uart_t t_st, next_t_st;
  logic [DIV_W-1:0] t_cnt, next_t_cnt;
  logic [2:0] t_bit, next_t_bit;
  logic [7:0] t_sh, next_t_sh;
  logic next_txd;

  assign buf_pop = (t_st == R_IDLE);
  assign line_idle = (t_st == R_IDLE) && !buf_vld && (b_st == B_IDLE);

  always_comb begin
    next_t_st = t_st;
    next_t_cnt = (t_cnt != '0) ? t_cnt - 1'b1 : div - 1'b1;
    next_t_bit = t_bit;
    next_t_sh = t_sh;
    next_txd = uart_txd_out;
    case (t_st)
      R_IDLE: begin
        next_t_cnt = div - 1'b1;
        if (buf_vld) begin
          next_t_st = R_START;
          next_t_sh = buf_data;
          next_txd = 1'b0;
        end
      end
      R_START: if (t_cnt == '0) begin
        next_t_st = R_DATA;
        next_t_bit = 3'h0;
        next_txd = t_sh[0];
      end
      R_DATA: if (t_cnt == '0) begin
        next_t_sh = t_sh >> 1;
        next_t_bit = t_bit + 3'h1;
        next_txd = (t_bit == 3'h7) ? 1'b1 : t_sh[1];
        if (t_bit == 3'h7) next_t_st = R_STOP;
      end
      default: if (t_cnt == '0) next_t_st = R_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      t_st <= R_IDLE;
      t_cnt <= '0;
      t_bit <= 3'h0;
      t_sh <= 8'h00;
      uart_txd_out <= 1'b1;
    end else begin
      t_st <= next_t_st;
      t_cnt <= next_t_cnt;
      t_bit <= next_t_bit;
      t_sh <= next_t_sh;
      uart_txd_out <= next_txd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_rate_change_cause: assert property (
    $changed(baud_fast_out) |-> $past(baud_req && line_idle && !ans_pend))
    else $error("link rate changed without a granted command");
  a_type_then_len: assert property (
    (push_ok && b_st == B_TYPE) |=> (b_st == B_LEN && push))
    else $error("length byte does not follow type byte");
  a_len_in_range: assert property ((push && b_st == B_LEN) |->
    cur_byte <= MAX_LEN) else $error("length byte above maximum");
  a_crc_no_pad: assert property (
    (push_ok && b_st == B_DATA && {3'h0, b_cnt} == b_len - 8'h01)
    |=> b_st == B_CRCL) else $error("check value not after last byte");
  a_answer_deadline: assert property (
    ans_age < AGE_W'(ANSWER_LIMIT)) else $error("answer deadline missed");
  a_answer_class: assert property (
    (push && b_st == B_TYPE && b_src == SRC_ANS) |->
    cur_byte[7:6] == (ans_err ? CLS_ERR : CLS_RSP))
    else $error("answer class wrong");
  a_answer_code: assert property (
    (push && b_st == B_TYPE && b_src == SRC_ANS) |->
    cur_byte[5:0] == ans_code) else $error("answer code not echoed");
  a_no_reserved: assert property (
    (push && b_st == B_TYPE) |-> cur_byte != TYPE_RSVD)
    else $error("reserved report type sent");
  a_bad_dropped: assert property (
    (rx_byte_vld && p_st == P_CRCH && !crc_ok) |=> !$rose(ans_pend))
    else $error("corrupt packet answered");
  a_tick_pending: assert property (
    tick |=> ((temp_pend & $past(temp_select_in)) == $past(temp_select_in)))
    else $error("selected sensor not queued on tick");

  c_ping_answered: cover property (ans_done && !ans_err && ans_len != 8'h00);
  c_error_answered: cover property (ans_done && ans_err);
  c_key_report: cover property (b_st == B_IDLE && next_b_src == SRC_KEY &&
                                next_b_st == B_TYPE);
  c_rate_switch: cover property ($rose(baud_fast_out));

endmodule : hpl_link

// >>> src/hpl_pkg.sv
// Constants, codes and helper functions for the host packet link.
// Assumes a single 50 MHz core clock shared by every user of the package.
package hpl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_SLOW = 19200;
  localparam int BAUD_FAST = 115200;
  localparam int DIV_W = 12;
  localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'(CLK_HZ / BAUD_SLOW);
  localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'(CLK_HZ / BAUD_FAST);
  localparam int ANSWER_MS = 250;
  localparam int ANSWER_CYC = CLK_HZ / 1000 * ANSWER_MS;
  localparam int AGE_W = 24;
  localparam int REPORT_MS = 1000;
  localparam int REPORT_CYC = CLK_HZ / 1000 * REPORT_MS;
  localparam int SEC_W = 26;

  ////////////////////////////////////////////////////////////////////////
  // Packet layout and codes
  localparam int MAX_PAY = 18;
  localparam logic [7:0] MAX_LEN = 8'h12;
  localparam logic [7:0] PING_MAX_LEN = 8'h10;
  localparam logic [1:0] CLS_CMD = 2'h0;
  localparam logic [1:0] CLS_RSP = 2'h1;
  localparam logic [1:0] CLS_ERR = 2'h3;
  localparam logic [5:0] CODE_PING = 6'h00;
  localparam logic [5:0] CODE_BAUD = 6'h21;
  localparam logic [7:0] TYPE_KEY = 8'h80;
  localparam logic [7:0] TYPE_RSVD = 8'h81;
  localparam logic [7:0] TYPE_TEMP = 8'h82;
  localparam logic [7:0] KEY_LEN = 8'h01;
  localparam logic [7:0] TEMP_LEN = 8'h03;
  localparam logic [7:0] BAUD_LEN = 8'h01;
  localparam logic [7:0] BAUD_SEL_FAST = 8'h01;
  localparam logic [7:0] KEY_CODE_BASE = 8'h01;
  localparam int NUM_KEYS = 6;
  localparam int NUM_SENSORS = 32;
  localparam logic [1:0] SRC_ANS = 2'h1;
  localparam logic [1:0] SRC_KEY = 2'h2;
  localparam logic [1:0] SRC_TEMP = 2'h3;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;

  ////////////////////////////////////////////////////////////////////////
  // Reflected CCITT update, one byte at a time
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  // Index of the lowest set bit, zero when none
  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction : first_set

endpackage : hpl_pkg

// >>> tb/hpl_host_model.sv
// Host side of the serial link: byte-level 8N1 sender and receiver.
// Assumes the bench sets fast once the device has switched its rate.
`timescale 1ns/100ps
module hpl_host_model (
  // Clock and serial lines
  input wire logic core_clk_in,
  output logic rxd_out,
  input wire logic txd_in
);
  import hpl_pkg::*;
  logic fast = 1'b0;
  int unsigned bt;
  initial rxd_out = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Start bit, eight data bits LSB first, stop bit; idles high after
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    bt = fast ? DIV_FAST : DIV_SLOW;
    for (int i = 0; i < 10; i++) begin
      rxd_out = f[i];
      repeat (bt) @(negedge core_clk_in);
    end
  endtask : put
  // Bounded hunt for a start bit, then mid-bit sampling; ok low on none
  task automatic get(input int lim, output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b = 8'h00;
    bt = fast ? DIV_FAST : DIV_SLOW;
    for (int n = 0; n < lim && !ok; n++) begin
      @(negedge core_clk_in);
      ok = !txd_in;
    end
    if (ok) begin
      repeat (bt / 2) @(negedge core_clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (bt) @(negedge core_clk_in);
        b[i] = txd_in;
      end
      repeat (bt) @(negedge core_clk_in);
      ok = txd_in;
    end
  endtask : get
endmodule : hpl_host_model

// >>> tb/hpl_link_bench.sv
// Self-checking bench for hpl_link with a host model on the serial pins.
// Assumes temperature reports stay off until the last test selects one.
`timescale 1ns/100ps
module hpl_link_bench;
  import hpl_pkg::*;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic rxd, txd, baud_fast_out;
  logic [5:0] kp = 6'h00;
  logic [5:0] kr = 6'h00;
  logic [5:0] kpm = 6'h3f;
  logic [5:0] krm = 6'h3e;
  logic [31:0] tsel = 32'h0000_0000;
  logic [4:0] tidx;
  logic [15:0] tdat = 16'h0000;
  int error_cnt = 0;
  int total_checks = 0;
  initial forever #10 core_clk_in = ~core_clk_in;
  hpl_link #(.ANSWER_LIMIT(200000), .REPORT_PERIOD(100000)) i_hpl_link (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .uart_rxd_in(rxd),
    .uart_txd_out(txd), .baud_fast_out(baud_fast_out),
    .key_press_in(kp), .key_release_in(kr), .key_press_mask_in(kpm),
    .key_release_mask_in(krm), .temp_select_in(tsel),
    .temp_idx_out(tidx), .temp_data_in(tdat));
  // Sensor value follows the index half a cycle after it moves
  always @(negedge core_clk_in) tdat = {8'h5a, 3'h0, tidx};
  hpl_host_model i_hpl_host_model (
    .core_clk_in(core_clk_in), .rxd_out(rxd), .txd_in(txd));
  ////////////////////////////////////////////////////////////////////////
  // Own reflected CRC, kept apart from the design's helper
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction : crc
  task automatic check(input logic [15:0] s, input logic [15:0] x);
    total_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : check
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  // A flipped CRC bit makes a damaged packet on purpose
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) i_hpl_host_model.put(q[i]);
  endtask : send
  task automatic expect_pkt(input logic [7:0] e[$]);
    logic [7:0] b;
    logic ok;
    logic [7:0] r[$];
    for (int i = 0; i < e.size() + 2; i++) begin
      i_hpl_host_model.get(i ? 20000 : 300000, b, ok);
      check({15'h0000, ok}, 16'h0001);
      if (!ok) test_done();
      r.push_back(b);
    end
    foreach (e[i]) check({8'h00, r[i]}, {8'h00, e[i]});
    check({r[$], r[$-1]}, crc(e));
  endtask : expect_pkt
  task automatic quiet();
    logic [7:0] b;
    logic ok;
    i_hpl_host_model.get(30000, b, ok);
    check({15'h0000, ok}, 16'h0000);
  endtask : quiet
  ////////////////////////////////////////////////////////////////////////
  task automatic t_rate();
    check({15'h0000, baud_fast_out}, 16'h0000);
    send('{8'h21, 8'h01, 8'h01}, 1'b0);
    expect_pkt('{8'h61, 8'h00});
    repeat (3000) @(negedge core_clk_in);
    check({15'h0000, baud_fast_out}, 16'h0001);
    i_hpl_host_model.fast = 1'b1;
    $display("rate test done");
  endtask : t_rate
  task automatic t_ping_err();
    send('{8'h00, 8'h02, 8'ha5, 8'h3c}, 1'b0);
    expect_pkt('{8'h40, 8'h02, 8'ha5, 8'h3c});
    send('{8'h05, 8'h00}, 1'b0);
    expect_pkt('{8'hc5, 8'h00});
    send('{8'h21, 8'h01, 8'h02}, 1'b0);
    expect_pkt('{8'he1, 8'h00});
    $display("answer test done");
  endtask : t_ping_err
  // Bad CRC and overlong length are silent; a good packet still gets in
  task automatic t_bad();
    send('{8'h00, 8'h01, 8'h77}, 1'b1);
    quiet();
    i_hpl_host_model.put(8'h00);
    i_hpl_host_model.put(8'h13);
    quiet();
    send('{8'h00, 8'h00}, 1'b0);
    expect_pkt('{8'h40, 8'h00});
    $display("discard test done");
  endtask : t_bad
  // Release of key 0 is masked, so only two reports may appear
  task automatic t_key();
    kp = 6'h04;
    kr = 6'h21;
    @(negedge core_clk_in);
    kp = 6'h00;
    kr = 6'h00;
    expect_pkt('{8'h80, 8'h01, 8'h03});
    expect_pkt('{8'h80, 8'h01, 8'h0c});
    quiet();
    $display("key test done");
  endtask : t_key
  // Sensor 5 is selected only until its first report has arrived
  task automatic t_temp();
    tsel = 32'h0000_0020;
    expect_pkt('{8'h82, 8'h03, 8'h05, 8'h05, 8'h5a});
    tsel = 32'h0000_0000;
    check({11'h000, tidx}, 16'h0005);
    $display("temperature test done");
  endtask : t_temp
  initial begin
    repeat (6) @(negedge core_clk_in);
    nrst_in = 1'b1;
    t_rate();
    t_ping_err();
    t_bad();
    t_key();
    t_temp();
    test_done();
  end
endmodule : hpl_link_bench
